// *** dase_defines.svh ***
// constants for the data abort syndrome encoder
`ifndef DASE_DEFINES_SVH
`define DASE_DEFINES_SVH

// ----------------------------------------
// syndrome field positions
// ----------------------------------------
`define DASE_MAINT_BIT    8
`define DASE_WALK_BIT     7
`define DASE_WRITE_BIT    6
`define DASE_FSC_MSB      5
`define DASE_SYN_W        9

// ----------------------------------------
// fault status codes
// ----------------------------------------
`define DASE_FSC_ADDR_SIZE  6'h00
`define DASE_FSC_XLAT       6'h04
`define DASE_FSC_ACC_FLAG   6'h08
`define DASE_FSC_PERM       6'h0c
`define DASE_FSC_EXT        6'h10
`define DASE_FSC_TAG        6'h11
`define DASE_FSC_EXT_WLKM1  6'h13
`define DASE_FSC_EXT_WALK   6'h14
`define DASE_FSC_ECC        6'h18
`define DASE_FSC_ECC_WLKM1  6'h1b
`define DASE_FSC_ECC_WALK   6'h1c
`define DASE_FSC_ALIGN      6'h21
`define DASE_FSC_GPF_WLKM1  6'h23
`define DASE_FSC_GPF_WALK   6'h24
`define DASE_FSC_GPF        6'h28
`define DASE_FSC_UNSUP_ATOM 6'h35
`define DASE_FSC_UNSUP_HW   6'h31

`endif

// *** dase_pkg.sv ***
// types for the data abort syndrome encoder
package dase_pkg;

	// fault classes reported by the translation pipeline
	typedef enum logic [3:0] {
		DASE_ADDR_SIZE = 4'h0,
		DASE_XLAT      = 4'h1,
		DASE_ACC_FLAG  = 4'h2,
		DASE_PERM      = 4'h3,
		DASE_EXT       = 4'h4,
		DASE_TAG       = 4'h5,
		DASE_ECC       = 4'h6,
		DASE_ALIGN     = 4'h7,
		DASE_GPF       = 4'h8,
		DASE_UNSUP     = 4'h9
	} dase_class_t;

	// access origin
	typedef enum logic [1:0] {
		DASE_OP_LOAD   = 2'h0,
		DASE_OP_STORE  = 2'h1,
		DASE_OP_ATOMIC = 2'h2,
		DASE_OP_SYSTEM = 2'h3
	} dase_op_t;

endpackage

// *** dase_fsc_enc.sv ***
// combinational fault status code encoder
`timescale 1ns/1ps
`include "dase_defines.svh"

module dase_fsc_enc (
	// fault description
	input  wire dase_pkg::dase_class_t fclass,
	input  wire logic                  on_walk,
	input  wire logic                  level_m1,
	input  wire logic [1:0]            level,
	// feature presence
	input  wire logic                  large_address_extension,
	input  wire logic                  memory_tagging_extension,
	input  wire logic                  reliability_extension,
	input  wire logic                  realm_extension,
	// result
	output logic [5:0]                 fsc,
	output logic                       fsc_ok
);
	import dase_pkg::*;

	function automatic logic [5:0] lvl_code(input logic [5:0] base, input logic [1:0] lv);
		lvl_code = {base[5:2], lv};
	endfunction

	wire lm1_ok = large_address_extension;

	always_comb begin
		fsc    = `DASE_FSC_EXT;
		fsc_ok = 1'b1;
		unique case (fclass)
			DASE_ADDR_SIZE: fsc = lvl_code(`DASE_FSC_ADDR_SIZE, level);
			DASE_XLAT:      fsc = lvl_code(`DASE_FSC_XLAT, level);
			DASE_ACC_FLAG: begin
				fsc    = lvl_code(`DASE_FSC_ACC_FLAG, level);
				fsc_ok = (level != 2'h0) || lm1_ok;
			end
			DASE_PERM: begin
				fsc    = lvl_code(`DASE_FSC_PERM, level);
				fsc_ok = (level != 2'h0) || lm1_ok;
			end
			DASE_EXT: begin
				if (!on_walk) begin
					fsc = `DASE_FSC_EXT;
				end else if (level_m1) begin
					fsc    = `DASE_FSC_EXT_WLKM1;
					fsc_ok = lm1_ok;
				end else begin
					fsc = lvl_code(`DASE_FSC_EXT_WALK, level);
				end
			end
			DASE_TAG: begin
				fsc    = `DASE_FSC_TAG;
				fsc_ok = memory_tagging_extension;
			end
			DASE_ECC: begin
				fsc_ok = !reliability_extension;
				if (!on_walk) begin
					fsc = `DASE_FSC_ECC;
				end else if (level_m1) begin
					fsc    = `DASE_FSC_ECC_WLKM1;
					fsc_ok = !reliability_extension && lm1_ok;
				end else begin
					fsc = lvl_code(`DASE_FSC_ECC_WALK, level);
				end
			end
			DASE_ALIGN:     fsc = `DASE_FSC_ALIGN;
			DASE_GPF: begin
				fsc_ok = realm_extension;
				if (!on_walk) begin
					fsc = `DASE_FSC_GPF;
				end else if (level_m1) begin
					fsc    = `DASE_FSC_GPF_WLKM1;
					fsc_ok = realm_extension && lm1_ok;
				end else begin
					fsc = `DASE_FSC_GPF_WALK + {4'h0, level};
				end
			end
			DASE_UNSUP:     fsc = `DASE_FSC_UNSUP_ATOM;
			default:        fsc_ok = 1'b0;
		endcase
	end

endmodule

// *** dase_top.sv ***
// data abort syndrome encoder: captures the low syndrome fields
`timescale 1ns/1ps
`include "dase_defines.svh"

module dase_top #(
	parameter bit ATOMIC_WALK_RELAX = 1'b0
) (
	// clocking
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  clk_en,
	// abort report from the pipeline
	input  wire logic                  abort_take,
	input  wire dase_pkg::dase_class_t fault_class,
	input  wire dase_pkg::dase_op_t    access_op,
	input  wire logic                  is_cache_maint,
	input  wire logic                  is_addr_xlate,
	input  wire logic                  is_dcache_zero,
	input  wire logic                  stage2_fault,
	input  wire logic                  on_walk,
	input  wire logic                  level_m1,
	input  wire logic [1:0]            fault_level,
	input  wire logic                  read_would_fault,
	// feature presence
	input  wire logic                  large_address_extension,
	input  wire logic                  memory_tagging_extension,
	input  wire logic                  reliability_extension,
	input  wire logic                  realm_extension,
	// syndrome fields
	output logic                       cache_maint_fault_flag,
	output logic                       stage1_walk_fault_flag,
	output logic                       write_not_read_flag,
	output logic [5:0]                 data_fault_status_code,
	output logic                       syndrome_valid,
	output logic                       code_unsupported
);
	import dase_pkg::*;

	// ----------------------------------------
	// encoding
	// ----------------------------------------
	logic [5:0] enc_fsc;
	logic       enc_ok;

	dase_fsc_enc u_enc (
		.fclass                   (fault_class),
		.on_walk                  (on_walk),
		.level_m1                 (level_m1),
		.level                    (fault_level),
		.large_address_extension  (large_address_extension),
		.memory_tagging_extension (memory_tagging_extension),
		.reliability_extension    (reliability_extension),
		.realm_extension          (realm_extension),
		.fsc                      (enc_fsc),
		.fsc_ok                   (enc_ok)
	);

	wire is_system = is_cache_maint || is_addr_xlate;
	wire next_maint = is_system && !is_dcache_zero;

	// walk flag only for stage 2 faults
	wire next_walk = stage2_fault && on_walk;

	// atomic direction by read test, optional relaxation
	wire atomic_write = (ATOMIC_WALK_RELAX && next_walk) ? 1'b0 : !read_would_fault;

	// direction; other cases report write only for a plain store
	wire next_write = is_system ? 1'b1 :
		(access_op == DASE_OP_ATOMIC) ? atomic_write :
		(access_op == DASE_OP_STORE);

	// ----------------------------------------
	// capture
	// ----------------------------------------
	// fields load together; data flops need no reset
	always_ff @(posedge clk) begin
		if (clk_en && abort_take) begin
			cache_maint_fault_flag <= next_maint;
			stage1_walk_fault_flag <= next_walk;
			write_not_read_flag    <= next_write;
			// level passes through from the stage 2 lookup
			data_fault_status_code <= enc_fsc;
			code_unsupported       <= !enc_ok;
		end
	end

	// valid marks that the fields hold a captured abort
	// reset also waits for the clock enable, so a frozen block keeps its state
	always_ff @(posedge clk) begin
		if (clk_en) begin
			if (!rst_b) begin
				syndrome_valid <= 1'b0;
			end else if (abort_take) begin
				syndrome_valid <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_maint_capture: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && is_cache_maint && !is_dcache_zero
		|=> cache_maint_fault_flag)
		else $error("cache maint flag not captured");
	a_zero_no_maint: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && is_dcache_zero |=> !cache_maint_fault_flag)
		else $error("zero-by-address set cache maint flag");
	a_walk_set: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && stage2_fault && on_walk |=> stage1_walk_fault_flag)
		else $error("walk flag missing");
	a_walk_zero: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && !stage2_fault |=> !stage1_walk_fault_flag)
		else $error("walk flag set without stage 2 fault");
	a_write_dir: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && !is_system && access_op == DASE_OP_LOAD
		|=> !write_not_read_flag)
		else $error("load reported as write");
	a_write_system: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && is_system |=> write_not_read_flag)
		else $error("maintenance fault not write");
	a_write_atomic: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && !is_system && access_op == DASE_OP_ATOMIC
		&& !next_walk |=> write_not_read_flag == !$past(read_would_fault))
		else $error("atomic direction wrong");
	a_xlat_code: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && fault_class == DASE_XLAT
		|=> data_fault_status_code == {4'h1, $past(fault_level)})
		else $error("translation code wrong");
	a_align_code: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && fault_class == DASE_ALIGN
		|=> data_fault_status_code == 6'h21)
		else $error("alignment code wrong");
	a_hold_fields: assert property (@(posedge clk) disable iff (!rst_b)
		syndrome_valid && !(clk_en && abort_take) |=> $stable(data_fault_status_code)
		&& $stable(write_not_read_flag))
		else $error("fields changed without abort");
	a_addr_code: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && fault_class == DASE_ADDR_SIZE
		|=> data_fault_status_code == {4'h0, $past(fault_level)})
		else $error("address size code wrong");
	a_flag_code: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && fault_class == DASE_ACC_FLAG
		|=> data_fault_status_code == {4'h2, $past(fault_level)})
		else $error("access flag code wrong");
	a_flag_gate: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && fault_class == DASE_ACC_FLAG && fault_level == 2'h0
		&& !large_address_extension |=> code_unsupported)
		else $error("level 0 access flag not refused");
	a_perm_code: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && fault_class == DASE_PERM
		|=> data_fault_status_code == {4'h3, $past(fault_level)})
		else $error("permission code wrong");
	a_tag_code: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && fault_class == DASE_TAG && memory_tagging_extension
		|=> data_fault_status_code == 6'h11 && !code_unsupported)
		else $error("tag check code wrong");
	a_ext_walk: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && fault_class == DASE_EXT && on_walk && !level_m1
		|=> data_fault_status_code == {4'h5, $past(fault_level)})
		else $error("external walk code wrong");
	a_ecc_plain: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && fault_class == DASE_ECC && !on_walk
		&& !reliability_extension |=> data_fault_status_code == 6'h18 && !code_unsupported)
		else $error("parity code wrong");
	a_gpf_walk: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && fault_class == DASE_GPF && on_walk && !level_m1
		|=> data_fault_status_code == {4'h9, $past(fault_level)})
		else $error("granule walk code wrong");
	a_gpf_plain: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && fault_class == DASE_GPF && !on_walk
		|=> data_fault_status_code == 6'h28)
		else $error("granule code wrong");
	a_unsup_code: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take && fault_class == DASE_UNSUP
		|=> data_fault_status_code == 6'h35)
		else $error("unsupported atomic code wrong");
	a_valid_set: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en && abort_take |=> syndrome_valid)
		else $error("valid not set by capture");
	a_freeze_fields: assert property (@(posedge clk) disable iff (!rst_b)
		syndrome_valid && !clk_en |=> $stable(data_fault_status_code)
		&& $stable(syndrome_valid))
		else $error("fields changed while frozen");

endmodule

// *** dase_pipe_model.sv ***
// pipeline model that reports one fault to the encoder per request
`timescale 1ns/1ps

module dase_pipe_model (
	// clocking
	input  wire logic                  clk,
	// request from the bench
	input  wire logic                  go,
	input  wire logic [18:0]           stim,
	// fault report
	output logic                       abort_take,
	output dase_pkg::dase_class_t      fault_class,
	output dase_pkg::dase_op_t         access_op,
	output logic                       is_cache_maint,
	output logic                       is_addr_xlate,
	output logic                       is_dcache_zero,
	output logic                       stage2_fault,
	output logic                       on_walk,
	output logic                       level_m1,
	output logic [1:0]                 fault_level,
	output logic                       read_would_fault,
	// feature presence
	output logic                       large_address_extension,
	output logic                       memory_tagging_extension,
	output logic                       reliability_extension,
	output logic                       realm_extension
);
	import dase_pkg::*;

	logic [18:0] held;

	initial begin
		abort_take = 1'b0;
		held = 19'h00000;
	end

	// each idle cycle inverts all but the four feature bits of the held report, so stale fields never look valid
	always @(posedge clk) begin
		abort_take <= go;
		held <= go ? stim : {~held[18:4], held[3:0]};
	end

	assign fault_class = dase_class_t'(held[18:15]);
	assign access_op = dase_op_t'(held[14:13]);
	assign {is_cache_maint, is_addr_xlate, is_dcache_zero, stage2_fault, on_walk} = held[12:8];
	assign level_m1 = held[7];
	assign fault_level = held[6:5];
	assign read_would_fault = held[4];
	assign {large_address_extension, memory_tagging_extension} = held[3:2];
	assign {reliability_extension, realm_extension} = held[1:0];
endmodule

// *** data_abort_syndrome_encoder_bench.sv ***
// self-checking bench for the data abort syndrome encoder
`timescale 1ns/1ps

`define CHK(what, exp, got) \
	n_compared++; \
	if ((got) !== (exp)) begin \
		n_errors++; \
		$display("Error %s expected %h seen %h", what, exp, got); \
	end

module data_abort_syndrome_encoder_bench;
	import dase_pkg::*;

	logic        clk, rst_b, clk_en, go;
	logic [18:0] stim;
	int          n_errors, n_compared;
	wire logic   abort_take, is_cache_maint, is_addr_xlate, is_dcache_zero, stage2_fault;
	wire logic   on_walk, level_m1, read_would_fault, large_address_extension;
	wire logic   memory_tagging_extension, reliability_extension, realm_extension;
	wire logic   cache_maint_fault_flag, stage1_walk_fault_flag, write_not_read_flag;
	wire logic   syndrome_valid, code_unsupported;
	wire logic [1:0] fault_level;
	wire logic [5:0] data_fault_status_code;
	dase_class_t fault_class;
	dase_op_t    access_op;
	wire logic [9:0] got = {code_unsupported, cache_maint_fault_flag, stage1_walk_fault_flag,
		write_not_read_flag, data_fault_status_code};

	// class, op, {maint, xlate, zero, stage2, walk}, level -1, level, read faults, features
	logic [28:0] rows [26] = '{
		{4'h1,2'h1,5'h00,1'b0,2'h2,1'b0,4'h0,10'h046}, {4'h0,2'h0,5'h00,1'b0,2'h0,1'b0,4'h0,10'h000},
		{4'h2,2'h0,5'h00,1'b0,2'h1,1'b0,4'h0,10'h009}, {4'h2,2'h0,5'h00,1'b0,2'h0,1'b0,4'h8,10'h008},
		{4'h2,2'h0,5'h00,1'b0,2'h0,1'b0,4'h0,10'h208}, {4'h3,2'h1,5'h00,1'b0,2'h3,1'b0,4'h0,10'h04f},
		{4'h3,2'h0,5'h00,1'b0,2'h0,1'b0,4'h8,10'h00c}, {4'h4,2'h0,5'h00,1'b0,2'h0,1'b0,4'h0,10'h010},
		{4'h4,2'h0,5'h01,1'b0,2'h3,1'b0,4'h0,10'h017}, {4'h4,2'h0,5'h01,1'b1,2'h0,1'b0,4'h8,10'h013},
		{4'h5,2'h0,5'h00,1'b0,2'h0,1'b0,4'h4,10'h011}, {4'h6,2'h0,5'h00,1'b0,2'h0,1'b0,4'h0,10'h018},
		{4'h6,2'h0,5'h01,1'b0,2'h0,1'b0,4'h0,10'h01c}, {4'h6,2'h0,5'h01,1'b1,2'h0,1'b0,4'h8,10'h01b},
		{4'h7,2'h1,5'h00,1'b0,2'h0,1'b0,4'h0,10'h061}, {4'h8,2'h0,5'h01,1'b0,2'h0,1'b0,4'h1,10'h024},
		{4'h8,2'h0,5'h01,1'b1,2'h0,1'b0,4'h9,10'h023}, {4'h8,2'h0,5'h00,1'b0,2'h0,1'b0,4'h1,10'h028},
		{4'h9,2'h0,5'h00,1'b0,2'h0,1'b0,4'h0,10'h035}, {4'h1,2'h3,5'h10,1'b0,2'h1,1'b0,4'h0,10'h145},
		{4'h1,2'h3,5'h08,1'b0,2'h1,1'b0,4'h0,10'h145}, {4'h3,2'h1,5'h14,1'b0,2'h1,1'b0,4'h0,10'h04d},
		{4'h1,2'h0,5'h03,1'b0,2'h1,1'b0,4'h0,10'h085}, {4'h3,2'h2,5'h00,1'b0,2'h2,1'b1,4'h0,10'h00e},
		{4'h3,2'h2,5'h00,1'b0,2'h2,1'b0,4'h0,10'h04e}, {4'h1,2'h2,5'h03,1'b0,2'h1,1'b0,4'h0,10'h0c5}};

	dase_pipe_model u_dase_pipe_model (.clk, .go, .stim, .abort_take, .fault_class,
		.access_op, .is_cache_maint, .is_addr_xlate, .is_dcache_zero, .stage2_fault, .on_walk,
		.level_m1, .fault_level, .read_would_fault, .large_address_extension,
		.memory_tagging_extension, .reliability_extension, .realm_extension);

	dase_top u_dase_top (.clk, .rst_b, .clk_en, .abort_take, .fault_class, .access_op,
		.is_cache_maint, .is_addr_xlate, .is_dcache_zero, .stage2_fault, .on_walk, .level_m1,
		.fault_level, .read_would_fault, .large_address_extension, .memory_tagging_extension,
		.reliability_extension, .realm_extension, .cache_maint_fault_flag,
		.stage1_walk_fault_flag, .write_not_read_flag, .data_fault_status_code,
		.syndrome_valid, .code_unsupported);

	task stop_test;
		if (n_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// one report: model drives it an edge later, the encoder captures on the edge after
	task send(input logic [18:0] s);
		go <= 1'b1;
		stim <= s;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		@(negedge clk);
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (500) @(posedge clk);
		n_errors++;
		stop_test;
	end

	initial begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		go = 1'b0;
		stim = 19'h00000;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		`CHK("valid after reset", 1'b0, syndrome_valid)
		for (int i = 0; i < 26; i++) begin
			@(posedge clk);
			send(rows[i][28:10]);
			`CHK("syndrome", rows[i][9:0], got)
		end
		`CHK("valid after capture", 1'b1, syndrome_valid)
		// frozen clock enable must ignore a report
		@(posedge clk);
		clk_en <= 1'b0;
		send(rows[0][28:10]);
		`CHK("frozen syndrome", rows[25][9:0], got)
		@(posedge clk);
		clk_en <= 1'b1;
		// back-to-back reports, each captured whole
		@(posedge clk);
		go <= 1'b1;
		stim <= rows[5][28:10];
		@(posedge clk);
		stim <= rows[22][28:10];
		@(posedge clk);
		go <= 1'b0;
		@(negedge clk);
		`CHK("first of pair", rows[5][9:0], got)
		@(negedge clk);
		`CHK("second of pair", rows[22][9:0], got)
		// reset in mid-run drops the valid flag
		@(posedge clk);
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		`CHK("valid after second reset", 1'b0, syndrome_valid)
		stop_test;
	end
endmodule
